//--- instruction_opcode_decoder.sv
/*
  Decoder for the transfer, arithmetic, logic and shift/rotate opcodes.
  Assumes the fetch queue presents up to four bytes with a one-cycle valid
  strobe on the processor clock; results appear one cycle later.
*/
// Functional notes
// - Upper six bits zero: register/memory sum, direction and size, addressing byte.
// - Carry-sum, difference, or, xor register/memory forms decoded from six-bit prefixes.
// - 8E loads segment register selected by addressing middle field, top bit zero.
// - 8C stores segment register chosen by addressing middle field.
// - 37 is ASCII fix after sum, single byte.
// - 27 is packed decimal fix after sum, single byte.
// - F6/F7 middle 111 signed division, 010 inversion.
// - 98 extends byte accumulator into word accumulator.
// - 99 extends word accumulator into register pair.
// - Shift group middle 100, 101, 111: left, logical right, arithmetic right.
// - Shift group middle 000 to 011: rotates left, right, carry left, carry right.
// - 84/85 with addressing byte is flags-only AND, no writeback.
// - F6/F7 middle 000: flags-only AND with one or two immediate bytes.
// - A8/A9 flags-only AND with accumulator, immediate bytes, no addressing.
// - Size bit set means word, clear means byte.
// - Sign-extend and size both one: one immediate byte sign-extended; F7 with w set takes two immediate bytes here.
// - Class 01: one displacement byte sign-extended to 16 bits.
`timescale 1ns/1ns
`default_nettype none
module instruction_opcode_decoder (
  input wire logic clock,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire opdec_pkg::fetch_t fetch,
  output var opdec_pkg::decode_t result,
  output logic result_valid
);

  // Decode of the bytes on the fetch port, registered only when the strobe is high
  opdec_pkg::decode_t next_result;

  // Displacement bytes implied by the addressing byte
  function automatic logic [1:0] disp_count(input logic [7:0] m);
    if (m[7:6] == opdec_pkg::MOD_DISP8) begin
      disp_count = 2'h1;
    end else if (m[7:6] == opdec_pkg::MOD_DISP16) begin
      disp_count = 2'h2;
    end else if (m[7:6] == 2'h0 && m[2:0] == opdec_pkg::RM_DIRECT) begin
      // Direct address: mod 00 with r/m 110 carries a full 16-bit address
      disp_count = 2'h2;
    end else begin
      // Register operand, or a memory operand that needs no displacement
      disp_count = 2'h0;
    end
  endfunction : disp_count

  // Six-bit prefix match with the d and w bits left out
  function automatic logic prefix6(input logic [7:0] o, input logic [5:0] p);
    prefix6 = (o[7:2] == p);
  endfunction : prefix6

  // Seven-bit prefix match with only the w bit left out
  function automatic logic prefix7(input logic [7:0] o, input logic [6:0] p);
    prefix7 = (o[7:1] == p);
  endfunction : prefix7

  // Immediate length of the w-sized forms
  function automatic logic [1:0] imm_count(input logic w);
    if (w) begin
      imm_count = 2'h2;
    end else begin
      imm_count = 2'h1;
    end
  endfunction : imm_count

  // Byte field widened with its sign, for displacement and immediate alike
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction : sext8

  always_comb begin
    logic [7:0] op;
    logic [2:0] mid;
    logic [1:0] dn;
    logic [7:0] lo;
    logic [7:0] hi;
    op = fetch.opcode;
    mid = fetch.modrm[5:3];
    dn = 2'h0;
    lo = 8'h00;
    hi = 8'h00;
    // Defaults fit the forms with an addressing byte; forms without one override
    next_result = '0;
    next_result.op = opdec_pkg::OPC_NONE;
    next_result.legal = 1'b1;
    next_result.word = op[0];
    next_result.dir = op[1];
    next_result.reg_sel = mid;
    next_result.has_modrm = 1'b1;
    if (prefix6(op, opdec_pkg::PFX_SUM)) begin
      next_result.op = opdec_pkg::OPC_SUM;
    end else if (prefix6(op, opdec_pkg::PFX_CARRY_SUM)) begin
      next_result.op = opdec_pkg::OPC_CARRY_SUM;
    end else if (prefix6(op, opdec_pkg::PFX_DIFF)) begin
      next_result.op = opdec_pkg::OPC_DIFF;
    end else if (prefix6(op, opdec_pkg::PFX_OR)) begin
      next_result.op = opdec_pkg::OPC_OR;
    end else if (prefix6(op, opdec_pkg::PFX_XOR)) begin
      next_result.op = opdec_pkg::OPC_XOR;
    end else if (op == opdec_pkg::OP_SEG_LOAD) begin
      // Only four segment registers exist: a set top bit of the middle field is refused
      next_result.op = opdec_pkg::OPC_SEG_LOAD;
      next_result.word = 1'b1;
      next_result.dir = 1'b1;
      next_result.legal = ~mid[2];
    end else if (op == opdec_pkg::OP_SEG_STORE) begin
      next_result.op = opdec_pkg::OPC_SEG_STORE;
      next_result.word = 1'b1;
      next_result.dir = 1'b0;
      next_result.legal = ~mid[2];
    end else if (prefix7(op, opdec_pkg::PFX_TEST_RM)) begin
      // Flags-only AND has a fixed operand order: no direction bit
      next_result.op = opdec_pkg::OPC_TEST_REG;
      next_result.dir = 1'b0;
    end else if (prefix7(op, opdec_pkg::PFX_UNARY_GRP)) begin
      // Middles other than 000, 010 and 111 belong to forms not decoded here
      next_result.dir = 1'b0;
      case (mid)
        opdec_pkg::MID_SQUOT: next_result.op = opdec_pkg::signed_quotient_op;
        opdec_pkg::MID_INVERT: next_result.op = opdec_pkg::OPC_INVERT;
        opdec_pkg::MID_TEST: begin
          next_result.op = opdec_pkg::OPC_TEST_IMM;
          next_result.imm_bytes = imm_count(op[0]);
        end
        default: next_result.legal = 1'b0;
      endcase
    end else if (prefix6(op, opdec_pkg::PFX_SHIFT_GRP)) begin
      // Middle 110 names no operation in this group and is refused
      next_result.dir = op[1]; // Count from CL when set, else one
      case (mid)
        3'h0: next_result.op = opdec_pkg::left_rotate;
        3'h1: next_result.op = opdec_pkg::right_rotate;
        3'h2: next_result.op = opdec_pkg::carry_left_rotate;
        3'h3: next_result.op = opdec_pkg::carry_right_rotate;
        3'h4: next_result.op = opdec_pkg::left_shift_op;
        3'h5: next_result.op = opdec_pkg::logical_right_shift;
        3'h7: next_result.op = opdec_pkg::arith_right_shift;
        default: next_result.legal = 1'b0;
      endcase
    end else begin
      // No addressing byte: immediate data starts at the second byte
      next_result.has_modrm = 1'b0;
      next_result.reg_sel = 3'h0;
      next_result.dir = 1'b0;
      if (prefix7(op, opdec_pkg::PFX_TEST_ACC)) begin
        next_result.op = opdec_pkg::OPC_TEST_ACC;
        next_result.imm_bytes = imm_count(op[0]);
      end else if (op == opdec_pkg::OP_ASCII_FIX) begin
        next_result.op = opdec_pkg::ascii_fix_after_sum;
        next_result.word = 1'b0;
      end else if (op == opdec_pkg::OP_BCD_FIX) begin
        next_result.op = opdec_pkg::bcd_fix_after_sum;
        next_result.word = 1'b0;
      end else if (op == opdec_pkg::OP_BYTE_EXT) begin
        next_result.op = opdec_pkg::byte_to_word_extend;
        next_result.word = 1'b0;
      end else if (op == opdec_pkg::OP_WORD_EXT) begin
        next_result.op = opdec_pkg::word_to_dword_extend;
        next_result.word = 1'b1;
      end else begin
        next_result.legal = 1'b0;
        next_result.word = 1'b0;
      end
    end
    // Immediate form with s:w=11 carries one sign-extended byte; no form decoded here
    // reaches it, since w=1 always gives two immediate bytes.
    if (next_result.has_modrm) begin
      dn = disp_count(fetch.modrm);
    end
    next_result.disp_bytes = dn;
    if (dn == 2'h1) begin
      next_result.disp = sext8(fetch.b2);
    end else if (dn == 2'h2) begin
      next_result.disp = {fetch.b3, fetch.b2};
    end
    // Immediate follows the displacement; only four bytes are visible
    if (next_result.has_modrm) begin
      lo = (dn == 2'h0) ? fetch.b2 : fetch.b3;
      hi = (dn == 2'h0) ? fetch.b3 : 8'h00;
    end else begin
      lo = fetch.modrm;
      hi = fetch.b2;
    end
    if (next_result.imm_bytes == 2'h2) begin
      next_result.imm = {hi, lo};
    end else if (next_result.imm_bytes == 2'h1 && op[1:0] == 2'h3) begin
      next_result.imm = sext8(lo);
    end else if (next_result.imm_bytes == 2'h1) begin
      next_result.imm = {8'h00, lo};
    end
    // Length lets the fetch queue step to the next opcode without a decode of its own
    next_result.length = 3'h1 + {2'h0, next_result.has_modrm} + {1'b0, dn}
      + {1'b0, next_result.imm_bytes};
  end

  // Result holds between strobes so the datapath may read it late
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result <= '0;
    end else if (fetch_valid) begin
      result <= next_result;
    end
  end

  // One-cycle pulse marking the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= fetch_valid;
    end
  end

endmodule : instruction_opcode_decoder
`default_nettype wire

//--- opdec_pkg.sv
/*
  Shared constants and types for the instruction opcode decoder.
  Assumes a single 100 MHz clock domain; used by the decoder, its checker, the fetch model and the testbench.
*/
`default_nettype none
package opdec_pkg;
  localparam logic [5:0] PFX_SUM = 6'h00;
  localparam logic [5:0] PFX_CARRY_SUM = 6'h04;
  localparam logic [5:0] PFX_DIFF = 6'h0A;
  localparam logic [5:0] PFX_OR = 6'h02;
  localparam logic [5:0] PFX_XOR = 6'h0C;
  localparam logic [5:0] PFX_SHIFT_GRP = 6'h34;
  localparam logic [6:0] PFX_UNARY_GRP = 7'h7B;
  localparam logic [6:0] PFX_TEST_RM = 7'h42;
  localparam logic [6:0] PFX_TEST_ACC = 7'h54;
  localparam logic [7:0] OP_SEG_LOAD = 8'h8E;
  localparam logic [7:0] OP_SEG_STORE = 8'h8C;
  localparam logic [7:0] OP_ASCII_FIX = 8'h37;
  localparam logic [7:0] OP_BCD_FIX = 8'h27;
  localparam logic [7:0] OP_BYTE_EXT = 8'h98;
  localparam logic [7:0] OP_WORD_EXT = 8'h99;
  localparam logic [2:0] MID_TEST = 3'h0;
  localparam logic [2:0] MID_INVERT = 3'h2;
  localparam logic [2:0] MID_SQUOT = 3'h7;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  typedef enum logic [4:0] {
    OPC_NONE = 5'h00, OPC_SUM, OPC_CARRY_SUM, OPC_DIFF, OPC_OR, OPC_XOR,
    OPC_SEG_LOAD, OPC_SEG_STORE, ascii_fix_after_sum, bcd_fix_after_sum,
    signed_quotient_op, OPC_INVERT, byte_to_word_extend, word_to_dword_extend,
    left_shift_op, logical_right_shift, arith_right_shift, left_rotate,
    right_rotate, carry_left_rotate, carry_right_rotate, OPC_TEST_REG,
    OPC_TEST_IMM, OPC_TEST_ACC
  } op_class_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] b2;
    logic [7:0] b3;
  } fetch_t;

  typedef struct packed {
    op_class_t op;
    logic word;
    logic dir;
    logic has_modrm;
    logic [1:0] imm_bytes;
    logic [1:0] disp_bytes;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [2:0] reg_sel;
    logic [2:0] length;
    logic legal;
  } decode_t;
endpackage : opdec_pkg
`default_nettype wire

//--- decode_checker.sv
/*
  Port assertions for the instruction opcode decoder.
  Assumes one clock domain with an asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module decode_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire opdec_pkg::fetch_t fetch,
  input wire opdec_pkg::decode_t result,
  input wire logic result_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  answer_lat_a: assert property (fetch_valid |=> result_valid) else $error("answer missing");
  idle_hold_a: assert property (!fetch_valid |=> !result_valid && $stable(result)) else $error("spurious result");
  length_sum_a: assert property (result_valid |->
    result.length == 3'h1 + result.has_modrm + result.disp_bytes + result.imm_bytes) else $error("bad length");
  sum_size_a: assert property (fetch_valid && fetch.opcode[7:2] == 6'h00 |=>
    result.op == opdec_pkg::OPC_SUM && result.word == $past(fetch.opcode[0]) &&
    result.dir == $past(fetch.opcode[1])) else $error("bad sum");
  seg_select_a: assert property (fetch_valid && (fetch.opcode == opdec_pkg::OP_SEG_LOAD ||
    fetch.opcode == opdec_pkg::OP_SEG_STORE) |=> result.reg_sel == $past(fetch.modrm[5:3]) && result.word)
    else $error("bad segment select");
  shift_count_a: assert property (fetch_valid && fetch.opcode[7:2] == opdec_pkg::PFX_SHIFT_GRP |=>
    result.dir == $past(fetch.opcode[1]) && result.has_modrm) else $error("bad shift count source");
  seg_load_a: assert property (fetch_valid && fetch.opcode == opdec_pkg::OP_SEG_LOAD && !fetch.modrm[5] |=>
    result.op == opdec_pkg::OPC_SEG_LOAD && result.legal) else $error("bad segment load");
  disp_ext_a: assert property (fetch_valid && fetch.opcode[7:2] == opdec_pkg::PFX_DIFF &&
    fetch.modrm[7:6] == 2'h1 |=> result.disp == {{8{$past(fetch.b2[7])}}, $past(fetch.b2)}) else $error("bad disp");
  ascii_fix_a: assert property (fetch_valid && fetch.opcode == 8'h37 |-> ##1
    result.op == opdec_pkg::ascii_fix_after_sum && result.length == 3'h1) else $error("bad ascii fix");
  acc_test_a: assert property (fetch_valid && fetch.opcode[7:1] == 7'h54 |=>
    result.op == opdec_pkg::OPC_TEST_ACC && !result.has_modrm && result.imm_bytes == 2'h1 + $past(fetch.opcode[0]))
    else $error("bad acc test");
endmodule : decode_checker
bind instruction_opcode_decoder decode_checker chk (.clock(clock), .rst(rst), .fetch_valid(fetch_valid),
  .fetch(fetch), .result(result), .result_valid(result_valid));
`default_nettype wire

//--- fetch_source.sv
/*
  Model of the fetch queue that feeds the decoder.
  Assumes its tasks are called at the falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module fetch_source (
  output var logic fetch_valid,
  output var opdec_pkg::fetch_t fetch
);
  initial begin
    fetch_valid = 1'h0;
    fetch = '0;
  end
  task drive(input opdec_pkg::fetch_t bytes);
    fetch_valid = 1'h1;
    fetch = bytes;
  endtask : drive
  // Idle bytes are scrambled so latching outside the strobe shows up
  task stop();
    fetch_valid = 1'h0;
    fetch = ~fetch;
  endtask : stop
endmodule : fetch_source
`default_nettype wire

//--- tb.sv
/*
  Self-checking testbench for the instruction opcode decoder.
  Assumes fetch_source and decode_checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic fetch_valid;
  opdec_pkg::fetch_t fetch;
  opdec_pkg::decode_t result;
  logic result_valid;
  int num_errors = 0;
  int checks = 0;
  always #5 clock = ~clock;
  fetch_source src (.fetch_valid(fetch_valid), .fetch(fetch));
  instruction_opcode_decoder dut (.clock(clock), .rst(rst), .fetch_valid(fetch_valid), .fetch(fetch),
    .result(result), .result_valid(result_valid));
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // Back to back: each call drives the next fetch at the edge where it checks the last
  task run(input logic [31:0] b, input opdec_pkg::op_class_t op, input logic w, input logic [2:0] len,
    input logic lg, input logic [16:0] dv, input logic [16:0] iv);
    src.drive(b);
    @(negedge clock);
    check("valid", 32'h1, result_valid);
    check("legal", lg, result.legal);
    if (lg) begin
      check("op", op, result.op);
      check("word", w, result.word);
      check("length", len, result.length);
    end
    if (dv[16]) check("disp", dv[15:0], result.disp);
    if (iv[16]) check("imm", iv[15:0], result.imm);
  endtask : run
  task finish_test(input string name);
    src.stop();
    @(negedge clock);
    check("idle", 32'h0, result_valid);
    $display("%s done", name);
  endtask : finish_test
  task t_arith();
    run(32'h00C00000, opdec_pkg::OPC_SUM, 1'h0, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'h02C00000, opdec_pkg::OPC_SUM, 1'h0, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'h28863412, opdec_pkg::OPC_DIFF, 1'h0, 3'h4, 1'h1, 17'h11234, 17'h0);
    run(32'h13C10000, opdec_pkg::OPC_CARRY_SUM, 1'h1, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'h29468000, opdec_pkg::OPC_DIFF, 1'h1, 3'h3, 1'h1, 17'h1FF80, 17'h0);
    run(32'h0AC00000, opdec_pkg::OPC_OR, 1'h0, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'h31063412, opdec_pkg::OPC_XOR, 1'h1, 3'h4, 1'h1, 17'h11234, 17'h0);
    finish_test("arith");
  endtask : t_arith
  task t_seg_single();
    run(32'h8ED80000, opdec_pkg::OPC_SEG_LOAD, 1'h1, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'h8EF00000, opdec_pkg::OPC_NONE, 1'h0, 3'h0, 1'h0, 17'h0, 17'h0);
    run(32'h8CC80000, opdec_pkg::OPC_SEG_STORE, 1'h1, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'h37C00000, opdec_pkg::ascii_fix_after_sum, 1'h0, 3'h1, 1'h1, 17'h0, 17'h0);
    run(32'h27C00000, opdec_pkg::bcd_fix_after_sum, 1'h0, 3'h1, 1'h1, 17'h0, 17'h0);
    run(32'h98000000, opdec_pkg::byte_to_word_extend, 1'h0, 3'h1, 1'h1, 17'h0, 17'h0);
    run(32'h99000000, opdec_pkg::word_to_dword_extend, 1'h1, 3'h1, 1'h1, 17'h0, 17'h0);
    finish_test("seg_single");
  endtask : t_seg_single
  task t_unary_test();
    run(32'hF7F80000, opdec_pkg::signed_quotient_op, 1'h1, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'hF6D00000, opdec_pkg::OPC_INVERT, 1'h0, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'hF7C03412, opdec_pkg::OPC_TEST_IMM, 1'h1, 3'h4, 1'h1, 17'h0, 17'h11234);
    run(32'hF6C05600, opdec_pkg::OPC_TEST_IMM, 1'h0, 3'h3, 1'h1, 17'h0, 17'h10056);
    run(32'h85C00000, opdec_pkg::OPC_TEST_REG, 1'h1, 3'h2, 1'h1, 17'h0, 17'h0);
    run(32'hA9341200, opdec_pkg::OPC_TEST_ACC, 1'h1, 3'h3, 1'h1, 17'h0, 17'h11234);
    run(32'hA8560000, opdec_pkg::OPC_TEST_ACC, 1'h0, 3'h2, 1'h1, 17'h0, 17'h10056);
    finish_test("unary_test");
  endtask : t_unary_test
  task t_shift();
    opdec_pkg::op_class_t sh [8] = '{opdec_pkg::left_rotate, opdec_pkg::right_rotate,
      opdec_pkg::carry_left_rotate, opdec_pkg::carry_right_rotate, opdec_pkg::left_shift_op,
      opdec_pkg::logical_right_shift, opdec_pkg::OPC_NONE, opdec_pkg::arith_right_shift};
    for (int i = 0; i < 8; i++) begin
      run({8'hD3, 2'h3, 3'(i), 19'h0}, sh[i], 1'h1, 3'h2, i != 6, 17'h0, 17'h0);
    end
    run(32'hD0E00000, opdec_pkg::left_shift_op, 1'h0, 3'h2, 1'h1, 17'h0, 17'h0);
    finish_test("shift");
  endtask : t_shift
  task give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'h0;
    t_arith();
    t_seg_single();
    t_unary_test();
    t_shift();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
